// File: rtl/ccdcm_pkg.sv
// constants, tables and carrier types of the capture mode and control block
//
// What this block does
// - free-run starts acquiring by itself after reset, no trigger needed
// - still mode takes exactly one image per falling edge of acquire request seen while idle
// - still sequence: flush, integrate, read out, then idle for next request
// - free-run loops integrate and readout without flushing
// - source jumper on external takes integration time and binning from lines
// - mode switch picks still or free-run; middle follows line, low is still
// - converter source external lets the three-wire port drive converter registers
// - converter source internal writes defaults into every converter register after reset
// - defaults: one channel, CDS, 3V span, green, unity gains, zero offsets
// - with converter source internal, each acquire request captures address and data switches and writes them
// - acquire-driven register writes act the same in still and free-run
// - sensor switch sets pixels per line and lines per frame
// - bin switch sets horizontal and vertical binning
// - integration time set by a coarse and a fine switch group
// - sync check disables converter bus and drives pixel or line count
// - line counter is binary, counts up from zero to last line
// - pixel counter counts up in gray code to last pixel
// - outputs 12-bit data, frame, line, pixel syncs and an exposure flag
// - exposure flag high for the whole integration and low otherwise
// - integration is a whole number of 10 ms unit periods
// - each pixel period lasts eight system clocks
package ccdcm_pkg;

  // timing
  localparam int CLK_KHZ = 10000;
  localparam int UNIT_INT_MS = 10;
  localparam int UNIT_INT_CYCLES = UNIT_INT_MS * CLK_KHZ;
  localparam int PIX_CLKS = 8;
  localparam logic [2:0] PIX_DIV_LAST = 3'(PIX_CLKS - 1);
  localparam logic [11:0] FLUSH_LINES = 12'hfa0;

  // capture mode switch positions
  localparam logic [1:0] CMS_STILL = 2'h0;
  localparam logic [1:0] CMS_LINE = 2'h1;
  localparam logic [1:0] CMS_FREE = 2'h2;

  // register port map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam int CTRL_ACQ_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;

  // converter registers and serial word
  localparam logic [3:0] ADC_REG_COUNT = 4'h8;
  localparam logic [7:0] ADC_CFG_DEFAULT = 8'h32;
  localparam logic [7:0] ADC_MUX_DEFAULT = 8'h09;
  localparam logic [7:0] ADC_LEVEL_DEFAULT = 8'h00;
  localparam logic [4:0] SER_LAST_BIT = 5'h0f;
  localparam logic SER_WRITE = 1'b0;

  // sensor table, index 15 down to 0; codes 13..15 repeat test mode 1
  localparam logic [15:0][12:0] SENSOR_PPL = {13'h064, 13'h064, 13'h064, 13'h8fc,
    13'h10cc, 13'h2bc, 13'h4b0, 13'h8fc, 13'h3e8, 13'hce4, 13'h6a4, 13'h8fc,
    13'h5dc, 13'h00a, 13'h5dc, 13'h064};
  localparam logic [15:0][12:0] SENSOR_LPF = {13'h002, 13'h002, 13'h002, 13'h898,
    13'h1068, 13'h28a, 13'h47e, 13'h640, 13'h28a, 13'h866, 13'h44c, 13'h866,
    13'h4b0, 13'h004, 13'h4b0, 13'h002};
  // bin factor per bin switch code, index 7 down to 0
  localparam logic [7:0][3:0] BIN_FACTOR = {4'h8, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'ha};
  // integration in unit periods, index 7 down to 0
  localparam logic [7:0][9:0] INT_COARSE_UNITS = {10'h384, 10'h2bc, 10'h1f4, 10'h190,
    10'h12c, 10'h0c8, 10'h064, 10'h000};
  localparam logic [7:0][9:0] INT_FINE_UNITS = {10'h050, 10'h032, 10'h01e, 10'h014,
    10'h00a, 10'h005, 10'h002, 10'h000};
  localparam logic [9:0] INT_MIN_UNITS = 10'h001;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic sload_n;
  } ccdcm_ser_s;

  typedef struct packed {
    logic source_select_jumper;
    logic [1:0] capture_mode_switch;
    logic adc_source_jumper;
    logic [2:0] adc_address_switch;
    logic [7:0] adc_data_switch;
    logic [3:0] sensor_select_switch;
    logic [2:0] bin_select_switch;
    logic [2:0] integration_coarse_switch;
    logic [2:0] integration_fine_switch;
    logic sync_check_enable_switch;
    logic sync_check_select_jumper;
  } ccdcm_sw_s;

  typedef struct packed {
    logic acquire_n;
    logic capture_mode_line;
    logic [5:0] integration;
    logic [2:0] bin;
    ccdcm_ser_s ser;
  } ccdcm_ext_s;

  typedef enum logic [1:0] {ST_IDLE, ST_FLUSH, ST_INTEG, ST_READ} ccdcm_state_e;

endpackage

// File: rtl/ccdcm_serial.sv
// three-wire serial writer for the converter registers
`timescale 1ns/10ps
`default_nettype none
module ccdcm_serial (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // request
  input wire logic start,
  input wire logic [2:0] addr,
  input wire logic [7:0] data,
  output logic busy,
  // serial line
  output ccdcm_pkg::ccdcm_ser_s ser
);

  logic [15:0] shreg_r;
  logic [4:0] bit_cnt_r;
  logic phase_r;

  // msb first, data changes with sclk low, converter samples on rising sclk
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      busy <= 1'b0;
      shreg_r <= 16'h0000;
      bit_cnt_r <= 5'h00;
      phase_r <= 1'b0;
      ser <= 3'h1;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        shreg_r <= {ccdcm_pkg::SER_WRITE, 4'h0, addr, data};
        bit_cnt_r <= 5'h00;
        phase_r <= 1'b0;
        ser.sload_n <= 1'b0;
        ser.sdata <= ccdcm_pkg::SER_WRITE;
        ser.sclk <= 1'b0;
      end
    end else if (!phase_r) begin
      ser.sclk <= 1'b1;
      phase_r <= 1'b1;
    end else begin
      ser.sclk <= 1'b0;
      phase_r <= 1'b0;
      if (bit_cnt_r == ccdcm_pkg::SER_LAST_BIT) begin
        busy <= 1'b0;
        ser.sload_n <= 1'b1;
        ser.sdata <= 1'b0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
        shreg_r <= {shreg_r[14:0], 1'b0};
        ser.sdata <= shreg_r[14];
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/ccdcm_capture_ctrl.sv
// capture mode, readout timing and converter programming of the sensor board
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module ccdcm_capture_ctrl #(
  parameter int UNIT_CYCLES = ccdcm_pkg::UNIT_INT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // board switches and jumpers
  input wire ccdcm_pkg::ccdcm_sw_s sw,
  // control input connector
  input wire ccdcm_pkg::ccdcm_ext_s ext,
  // converter
  input wire logic [11:0] adc_data_in,
  output logic adc_out_en,
  output ccdcm_pkg::ccdcm_ser_s adc_ser,
  // frame grabber
  output logic [11:0] video_data,
  output logic frame_sync,
  output logic line_sync,
  output logic pix_sync,
  output logic integrate
);

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  localparam int IN_W = $bits(ccdcm_pkg::ccdcm_sw_s) + $bits(ccdcm_pkg::ccdcm_ext_s) + 12;

  logic [IN_W-1:0] in_meta_r;
  logic [IN_W-1:0] in_sync_r;
  ccdcm_pkg::ccdcm_sw_s sw_s;
  ccdcm_pkg::ccdcm_ext_s ext_s;
  logic [11:0] adc_s;

  // switch, connector and converter data pins pass two flops; the first is read by the second only; the register port is used unsynchronised
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      in_meta_r <= '0;
      in_sync_r <= '0;
    end else begin
      in_meta_r <= {sw, ext, adc_data_in};
      in_sync_r <= in_meta_r;
    end
  end

  assign {sw_s, ext_s, adc_s} = in_sync_r;

  // ----------------------------------------------------------------
  // acquire edge and mode selection
  // ----------------------------------------------------------------
  logic acq_prev_r;
  logic acq_fall;
  logic soft_acq;
  logic acq_evt;
  logic still_mode;
  logic hold_r;
  logic [5:0] int_sel;
  logic [2:0] bin_sel;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      acq_prev_r <= 1'b0;
    end else begin
      acq_prev_r <= ext_s.acquire_n;
    end
  end

  assign acq_fall = acq_prev_r & ~ext_s.acquire_n;
  assign soft_acq = reg_wr & (reg_addr == ccdcm_pkg::REG_CTRL) &
    reg_wdata[ccdcm_pkg::CTRL_ACQ_BIT];
  assign acq_evt = acq_fall | soft_acq;

  assign still_mode = (sw_s.capture_mode_switch == ccdcm_pkg::CMS_STILL) |
    ((sw_s.capture_mode_switch == ccdcm_pkg::CMS_LINE) & ext_s.capture_mode_line);

  assign int_sel = sw_s.source_select_jumper ? ext_s.integration :
    {sw_s.integration_coarse_switch, sw_s.integration_fine_switch};
  assign bin_sel = sw_s.source_select_jumper ? ext_s.bin : sw_s.bin_select_switch;

  // ----------------------------------------------------------------
  // frame geometry and exposure length
  // ----------------------------------------------------------------
  logic [12:0] ppl;
  logic [12:0] lpf;
  logic [3:0] binf;
  logic [9:0] int_units;
  logic [9:0] int_sum;

  assign ppl = ccdcm_pkg::SENSOR_PPL[sw_s.sensor_select_switch];
  assign lpf = ccdcm_pkg::SENSOR_LPF[sw_s.sensor_select_switch];
  assign binf = ccdcm_pkg::BIN_FACTOR[bin_sel];
  assign int_sum = ccdcm_pkg::INT_COARSE_UNITS[int_sel[5:3]] +
    ccdcm_pkg::INT_FINE_UNITS[int_sel[2:0]];
  assign int_units = (int_sum == 10'h000) ? ccdcm_pkg::INT_MIN_UNITS : int_sum;

  // ----------------------------------------------------------------
  // pixel rate and unit integration dividers
  // ----------------------------------------------------------------
  ccdcm_pkg::ccdcm_state_e state_r;
  ccdcm_pkg::ccdcm_state_e state_nxt;
  logic [2:0] pix_div_r;
  logic pix_en;
  logic [16:0] unit_cnt_r;
  logic unit_tick;
  logic [9:0] int_cnt_r;
  logic [11:0] flush_cnt_r;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pix_div_r <= 3'h0;
    end else begin
      pix_div_r <= pix_div_r + 3'h1;
    end
  end

  assign pix_en = (pix_div_r == ccdcm_pkg::PIX_DIV_LAST);

  // unit divider restarts with each exposure so the length is a whole multiple
  always_ff @(posedge mclk) begin
    if (!reset_n || state_r != ccdcm_pkg::ST_INTEG) begin
      unit_cnt_r <= 17'h00000;
      int_cnt_r <= 10'h000;
    end else if (unit_tick) begin
      unit_cnt_r <= 17'h00000;
      int_cnt_r <= int_cnt_r + 10'h001;
    end else begin
      unit_cnt_r <= unit_cnt_r + 17'h00001;
    end
  end

  assign unit_tick = (unit_cnt_r == 17'(UNIT_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (!reset_n || state_r != ccdcm_pkg::ST_FLUSH) begin
      flush_cnt_r <= 12'h000;
    end else if (pix_en) begin
      flush_cnt_r <= flush_cnt_r + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // readout counters
  // ----------------------------------------------------------------
  logic [12:0] pix_cnt_r;
  logic [12:0] line_cnt_r;
  logic [3:0] hbin_r;
  logic [3:0] vbin_r;
  logic line_last_pix;
  logic frame_end;
  logic [12:0] pix_gray;

  assign line_last_pix = pix_en & (pix_cnt_r == 13'(ppl - 13'h0001));
  assign frame_end = (state_r == ccdcm_pkg::ST_READ) & line_last_pix &
    (line_cnt_r == 13'(lpf - 13'h0001));

  always_ff @(posedge mclk) begin
    if (!reset_n || state_r != ccdcm_pkg::ST_READ) begin
      pix_cnt_r <= 13'h0000;
      line_cnt_r <= 13'h0000;
      hbin_r <= 4'h0;
      vbin_r <= 4'h0;
    end else if (pix_en) begin
      hbin_r <= (hbin_r == 4'(binf - 4'h1)) ? 4'h0 : hbin_r + 4'h1;
      if (line_last_pix) begin
        pix_cnt_r <= 13'h0000;
        hbin_r <= 4'h0;
        line_cnt_r <= line_cnt_r + 13'h0001;
        vbin_r <= (vbin_r == 4'(binf - 4'h1)) ? 4'h0 : vbin_r + 4'h1;
      end else begin
        pix_cnt_r <= pix_cnt_r + 13'h0001;
      end
    end
  end

  assign pix_gray = pix_cnt_r ^ (pix_cnt_r >> 1);

  // ----------------------------------------------------------------
  // clocking state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ccdcm_pkg::ST_IDLE: begin
        if (!still_mode && !hold_r) begin
          state_nxt = ccdcm_pkg::ST_INTEG;
        end else if (still_mode && acq_evt) begin
          state_nxt = ccdcm_pkg::ST_FLUSH;
        end
      end
      ccdcm_pkg::ST_FLUSH: begin
        if (pix_en && flush_cnt_r == 12'(ccdcm_pkg::FLUSH_LINES - 12'h001)) begin
          state_nxt = ccdcm_pkg::ST_INTEG;
        end
      end
      ccdcm_pkg::ST_INTEG: begin
        if (unit_tick && int_cnt_r == 10'(int_units - 10'h001)) begin
          state_nxt = ccdcm_pkg::ST_READ;
        end
      end
      ccdcm_pkg::ST_READ: begin
        if (frame_end) begin
          state_nxt = (still_mode || hold_r) ? ccdcm_pkg::ST_IDLE : ccdcm_pkg::ST_INTEG;
        end
      end
      default: begin
        state_nxt = ccdcm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_r <= ccdcm_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // frame grabber outputs
  // ----------------------------------------------------------------
  logic line_valid;

  assign line_valid = (vbin_r == 4'(binf - 4'h1));

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      integrate <= 1'b0;
      frame_sync <= 1'b0;
      line_sync <= 1'b0;
      pix_sync <= 1'b0;
    end else begin
      integrate <= (state_nxt == ccdcm_pkg::ST_INTEG);
      frame_sync <= (state_nxt == ccdcm_pkg::ST_READ);
      line_sync <= (state_r == ccdcm_pkg::ST_READ) & line_valid;
      pix_sync <= (state_r == ccdcm_pkg::ST_READ) & line_valid & pix_en &
        (hbin_r == 4'(binf - 4'h1) || line_last_pix);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      video_data <= 12'h000;
      adc_out_en <= 1'b0;
    end else begin
      adc_out_en <= ~sw_s.sync_check_enable_switch;
      if (!sw_s.sync_check_enable_switch) begin
        video_data <= adc_s;
      end else if (sw_s.sync_check_select_jumper) begin
        video_data <= line_cnt_r[11:0];
      end else begin
        video_data <= pix_gray[11:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // converter register programming
  // ----------------------------------------------------------------
  logic [3:0] init_idx_r;
  logic init_done;
  logic pend_r;
  logic [2:0] pend_addr_r;
  logic [7:0] pend_data_r;
  logic ser_start;
  logic ser_busy;
  logic [2:0] ser_addr;
  logic [7:0] ser_data;
  ccdcm_pkg::ccdcm_ser_s ser_int;

  assign init_done = (init_idx_r == ccdcm_pkg::ADC_REG_COUNT);
  assign ser_start = ~sw_s.adc_source_jumper & ~ser_busy & (~init_done | pend_r);
  assign ser_addr = init_done ? pend_addr_r : init_idx_r[2:0];

  always_comb begin
    case (init_idx_r)
      4'h0: ser_data = ccdcm_pkg::ADC_CFG_DEFAULT;
      4'h1: ser_data = ccdcm_pkg::ADC_MUX_DEFAULT;
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: ser_data = ccdcm_pkg::ADC_LEVEL_DEFAULT;
      default: ser_data = pend_data_r;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      init_idx_r <= 4'h0;
    end else if (ser_start && !init_done) begin
      init_idx_r <= init_idx_r + 4'h1;
    end
  end

  // a new request in the cycle the old one is taken wins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pend_r <= 1'b0;
      pend_addr_r <= 3'h0;
      pend_data_r <= 8'h00;
    end else if (acq_evt && !sw_s.adc_source_jumper) begin
      pend_r <= 1'b1;
      pend_addr_r <= sw_s.adc_address_switch;
      pend_data_r <= sw_s.adc_data_switch;
    end else if (ser_start && init_done) begin
      pend_r <= 1'b0;
    end
  end

  ccdcm_serial u_serial (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(ser_start),
    .addr(ser_addr),
    .data(ser_data),
    .busy(ser_busy),
    .ser(ser_int)
  );

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      adc_ser <= 3'h1;
    end else begin
      adc_ser <= sw_s.adc_source_jumper ? ext_s.ser : ser_int;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hold_r <= 1'b0;
    end else if (reg_wr && reg_addr == ccdcm_pkg::REG_CTRL) begin
      hold_r <= reg_wdata[ccdcm_pkg::CTRL_HOLD_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || !reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else begin
      case (reg_addr)
        ccdcm_pkg::REG_CTRL: reg_rdata <= {30'h0, hold_r, 1'b0};
        ccdcm_pkg::REG_STATUS: reg_rdata <= {26'h0, init_done, ser_busy, integrate,
          still_mode, state_r};
        ccdcm_pkg::REG_COUNT: reg_rdata <= {3'h0, line_cnt_r, 3'h0, pix_cnt_r};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  logic [15:0] flush_len_r;
  always_ff @(posedge mclk) begin
    if (!reset_n || state_r != ccdcm_pkg::ST_FLUSH) begin
      flush_len_r <= 16'h0001;
    end else begin
      flush_len_r <= flush_len_r + 16'h0001;
    end
  end

  sequence s_leave_flush;
    state_r == ccdcm_pkg::ST_FLUSH ##1 state_r != ccdcm_pkg::ST_FLUSH;
  endsequence
  sequence s_leave_integ;
    state_r == ccdcm_pkg::ST_INTEG ##1 state_r != ccdcm_pkg::ST_INTEG;
  endsequence

  a_still_acq_start:
    assert property (state_r == ccdcm_pkg::ST_IDLE && still_mode && acq_evt
      |=> state_r == ccdcm_pkg::ST_FLUSH) else $error("still acquire did not start flush");
  a_busy_acq_ignored:
    assert property ((state_r == ccdcm_pkg::ST_INTEG || state_r == ccdcm_pkg::ST_READ) && acq_evt
      |=> state_r != ccdcm_pkg::ST_FLUSH) else $error("acquire restarted a busy capture");
  a_flush_then_integ:
    assert property (s_leave_flush |-> state_r == ccdcm_pkg::ST_INTEG)
      else $error("flush not followed by integration");
  a_integ_then_read:
    assert property (s_leave_integ |-> state_r == ccdcm_pkg::ST_READ)
      else $error("integration not followed by readout");
  a_flush_length:
    assert property (state_r == ccdcm_pkg::ST_FLUSH && state_nxt != ccdcm_pkg::ST_FLUSH
      |-> flush_len_r > 16'h7cf8 && flush_len_r <= 16'h7d00) else $error("flush length wrong");
  a_free_run_start:
    assert property (state_r == ccdcm_pkg::ST_IDLE && !still_mode && !hold_r
      |=> state_r == ccdcm_pkg::ST_INTEG) else $error("free-run did not start");
  a_free_no_flush:
    assert property (!still_mode && state_r == ccdcm_pkg::ST_READ
      |=> state_r != ccdcm_pkg::ST_FLUSH) else $error("free-run entered flush");
  a_exposure_flag:
    assert property (integrate == (state_r == ccdcm_pkg::ST_INTEG))
      else $error("exposure flag does not match integration");
  a_integ_whole_units:
    assert property (s_leave_integ |-> $past(unit_tick, 2) == 1'b0 ##0
      $past(int_cnt_r) == 10'($past(int_units) - 10'h001)) else $error("partial unit");
  a_pixel_period:
    assert property (pix_en |=> !pix_en [*7] ##1 pix_en) else $error("pixel period not 8");
  a_gray_step:
    assert property ($changed(pix_gray) && pix_cnt_r != 13'h0000
      |-> $countones(pix_gray ^ $past(pix_gray)) == 1) else $error("gray step broken");
  a_line_step:
    assert property ($changed(line_cnt_r) && state_r == ccdcm_pkg::ST_READ
      |-> line_cnt_r == $past(line_cnt_r) + 13'h0001) else $error("line count not binary");
  a_sync_line_out:
    assert property (sw_s.sync_check_enable_switch && sw_s.sync_check_select_jumper
      |=> !adc_out_en && video_data == $past(line_cnt_r[11:0])) else $error("sync check bad");
  a_mode_line:
    assert property (sw_s.capture_mode_switch == ccdcm_pkg::CMS_LINE
      |-> still_mode == ext_s.capture_mode_line) else $error("mode line not followed");
  a_default_cfg:
    assert property (ser_start && init_idx_r == 4'h0
      |-> ser_data == ccdcm_pkg::ADC_CFG_DEFAULT) else $error("wrong default config");
  a_acq_capture:
    assert property (acq_evt && !sw_s.adc_source_jumper
      |=> pend_r && pend_data_r == $past(sw_s.adc_data_switch)) else $error("switch not taken");

endmodule
`default_nettype wire

// File: sim/ccdcm_fe_model.sv
// converter side model: collects serial register writes, drives changing data
`timescale 1ns/10ps
`default_nettype none
module ccdcm_fe_model (
  // clock
  input wire logic mclk,
  // serial link from the block
  input wire ccdcm_pkg::ccdcm_ser_s ser,
  // converter data and collected registers
  output logic [11:0] adc_data,
  output logic [7:0][7:0] regs
);
  logic [15:0] sh;
  logic [4:0] nb;
  logic sclk_q;
  initial begin
    adc_data = 12'h000;
    regs = '1;
    nb = 5'h00;
    sclk_q = 1'b0;
  end
  always @(posedge mclk) begin
    // data never holds still, so a stale bus shows up
    adc_data <= adc_data + 12'h3a5;
    sclk_q <= ser.sclk;
    if (ser.sload_n) begin
      nb <= 5'h00;
    end else if (ser.sclk && !sclk_q) begin
      sh <= {sh[14:0], ser.sdata};
      nb <= nb + 5'h01;
    end
    // a whole write word lands in its register at load end
    if (ser.sload_n && nb == 5'h10 && !sh[15]) begin
      regs[sh[10:8]] <= sh[7:0];
    end
  end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench of the capture mode and control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rd;
  ccdcm_pkg::ccdcm_sw_s sw;
  ccdcm_pkg::ccdcm_ext_s ext;
  ccdcm_pkg::ccdcm_ser_s adc_ser;
  logic [11:0] adc_data_in, video_data;
  logic adc_out_en, frame_sync, line_sync, pix_sync, integrate;
  logic [7:0][7:0] fe_regs;
  logic [31:0] seed = 32'd87;
  int n_fail = 0;
  int tests_run = 0;
  int fine_u[8] = '{0, 2, 5, 10, 20, 30, 50, 80};
  int k, t, units;
  logic [2:0] a, f;
  logic [7:0] d;
  always #50 mclk = ~mclk;
  ccdcm_capture_ctrl #(.UNIT_CYCLES(20)) u_ccdcm_capture_ctrl (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sw(sw), .ext(ext), .adc_data_in(adc_data_in),
    .adc_out_en(adc_out_en), .adc_ser(adc_ser), .video_data(video_data),
    .frame_sync(frame_sync), .line_sync(line_sync), .pix_sync(pix_sync), .integrate(integrate));
  ccdcm_fe_model u_ccdcm_fe_model (.mclk(mclk), .ser(adc_ser), .adc_data(adc_data_in),
    .regs(fe_regs));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_on(ref logic s, input logic v, input int lim);
    t = 0;
    while (s !== v && t < lim) begin
      @(posedge mclk);
      #1;
      t++;
    end
    chk(s, v);
  endtask
  task automatic rd_reg(input logic [3:0] ad);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic wr_reg(input logic [3:0] ad, input logic [31:0] wd);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= wd;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic acquire();
    @(posedge mclk);
    ext.acquire_n <= 1'b0;
    repeat (4) @(posedge mclk);
    ext.acquire_n <= 1'b1;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sw = '0;
    ext = '0;
    ext.acquire_n = 1'b1;
    ext.ser.sload_n = 1'b1;
    ext.capture_mode_line = 1'b1;
    sw.capture_mode_switch = ccdcm_pkg::CMS_LINE;
    sw.sensor_select_switch = 4'h2;
    sw.bin_select_switch = 3'h1;
    sw.sync_check_enable_switch = 1'b1;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (1000) @(posedge mclk);
    for (k = 0; k < 8; k++) chk(fe_regs[k], k == 0 ? 8'h32 : k == 1 ? 8'h09 : 8'h00);
    $display("converter init test done");
    wr_reg(4'hc, 32'hffff_ffff);
    rd_reg(4'hc);
    chk(rd, 32'h0);
    rd_reg(ccdcm_pkg::REG_STATUS);
    chk(rd[1:0], 2'h0);
    a = 3'(rnd() % 6 + 2);
    d = rnd();
    f = rnd();
    units = fine_u[f] == 0 ? 1 : fine_u[f];
    sw.adc_address_switch <= a;
    sw.adc_data_switch <= d;
    sw.integration_fine_switch <= f;
    acquire();
    rd_reg(ccdcm_pkg::REG_STATUS);
    chk(rd[1:0], 2'h1);
    repeat (200) @(posedge mclk);
    chk(fe_regs[a], d);
    chk(integrate, 1'b0);
    wait_on(integrate, 1'b1, 40000);
    t = 0;
    while (integrate === 1'b1 && t < 5000) begin
      @(posedge mclk);
      #1;
      t++;
    end
    chk(t, units * 20);
    wait_on(frame_sync, 1'b1, 4);
    chk(adc_out_en, 1'b0);
    k = 0;
    while (k < 10 && frame_sync === 1'b1) begin
      @(posedge mclk);
      #1;
      if (pix_sync === 1'b1) begin
        chk(video_data, 12'(k ^ (k >> 1)));
        chk(line_sync, 1'b1);
        k++;
      end
    end
    sw.adc_data_switch <= ~d;
    acquire();
    wait_on(frame_sync, 1'b0, 2000);
    repeat (100) @(posedge mclk);
    chk(fe_regs[a], {~d});
    rd_reg(ccdcm_pkg::REG_STATUS);
    chk(rd[1:0], 2'h0);
    $display("still capture test done");
    ext.capture_mode_line <= 1'b0;
    wait_on(integrate, 1'b1, 20);
    wait_on(frame_sync, 1'b1, 2000);
    wait_on(frame_sync, 1'b0, 2000);
    wait_on(integrate, 1'b1, 20);
    $display("free-run test done");
    sw.sync_check_select_jumper <= 1'b1;
    wait_on(frame_sync, 1'b1, 2000);
    k = 0;
    while (frame_sync === 1'b1) begin
      @(posedge mclk);
      #1;
      if (pix_sync === 1'b1) begin
        chk(video_data, 12'(k / 10));
        k++;
      end
    end
    chk(k, 40);
    $display("line count test done");
    sw.sync_check_enable_switch <= 1'b0;
    repeat (5) @(posedge mclk);
    #1 chk(adc_out_en, 1'b1);
    $display("sync check off test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
